// file: core/scpc_pkg.sv
// Package for the system clock prescaler control block
package scpc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] SCPC_ADDR_TRIM = 4'h0;
    localparam logic [3:0] SCPC_ADDR_DIV = 4'h1;
    localparam logic [3:0] SCPC_ADDR_TIMER = 4'h2;
    localparam logic [3:0] SCPC_ADDR_STATUS = 4'h3;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int SCPC_CHG_EN_BIT = 7;
    localparam int SCPC_TRIM_RANGE_BIT = 7;
    localparam int SCPC_TIMER_EXT_BIT = 0;
    localparam logic [3:0] SCPC_SEL_MAX = 4'h8;
    localparam logic [3:0] SCPC_SEL_DIV8 = 4'h3;
    localparam logic [3:0] SCPC_SEL_DIV1 = 4'h0;
    localparam logic [3:0] SCPC_SRC_EXT = 4'h0;
    localparam logic [3:0] SCPC_SRC_LP128 = 4'h3;
    // Factory trim value; arbitrary default
    localparam logic [7:0] SCPC_TRIM_FACTORY = 8'h40;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int SCPC_CLK_KHZ = 40000;
    localparam logic [2:0] SCPC_CHG_WINDOW = 3'h4;
    localparam logic [22:0] SCPC_BASE_CK = 23'h00000E;
    localparam logic [22:0] SCPC_SLEEP_CK = 23'h000006;
    localparam int SCPC_DLY_SHORT_US = 4100;
    localparam int SCPC_DLY_LONG_US = 65000;
    localparam int SCPC_DLY_SHORT_CYC = SCPC_DLY_SHORT_US * SCPC_CLK_KHZ / 1000;
    localparam int SCPC_DLY_LONG_CYC = SCPC_DLY_LONG_US * SCPC_CLK_KHZ / 1000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCPC_ST_START,
        SCPC_ST_RUN,
        SCPC_ST_WAKE
    } scpc_state_type;

    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_delay_field;
        logic clock_output_fuse;
        logic divide_by_eight_fuse;
    } scpc_fuse_type;

endpackage

// file: core/scpc_top.sv
// Clock source select, start-up delay, clock output and glitch-free prescaler
// ----------------------------------------------------------------------------
// How it works
// ----------------------------------------------------------------------------
// How it works
// - Fuse code 0000 selects external clock
// - Start-up delay from delay field code
// - Timer external clock select bit chooses timer pin
// - Clock output fuse drives clock pin
// - Clock pin keeps toggling during reset
// - Clock pin carries prescaled clock
// - All derived clocks use selected divisor
// - Division changes produce no glitch
// - No intermediate frequency exceeds old or new
// - New division active at the end of the current old period
// - Change enable updates only with others zero
// - Change enable clears after four cycles
// - Rewriting change enable leaves window unchanged
// - Reset loads divide select from fuse
// - Any select value up to eight accepted regardless of fuse
// - Codes zero to eight divide by powers
// - Reset loads factory trim value
// - Trim top bit selects frequency range
// - Lower trim bits tune within range
// - Fuse code 0011 selects low-power oscillator
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module scpc_top
    import scpc_pkg::*;
#(
    parameter int DLY_SHORT_CYC = SCPC_DLY_SHORT_CYC,
    parameter int DLY_LONG_CYC = SCPC_DLY_LONG_CYC
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire scpc_fuse_type FUSES,
    input wire logic EXT_CLK_IN,
    input wire logic LP_OSC_IN,
    input wire logic RC_OSC_IN,
    input wire logic TIMER_PIN_IN,
    input wire logic TIMER_XTAL_IN,
    input wire logic WAKE_REQ,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    output logic SRC_CLK,
    output logic TIMER_CLK,
    output logic CLK_EN,
    output logic CLK_OUT_PIN,
    output logic CLK_OUT_OE_N,
    output logic CORE_READY,
    output logic [6:0] TRIM_FINE,
    output logic TRIM_RANGE
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [8:0] scpc_div_mask(input logic [3:0] sel);
        logic [8:0] m;
        m = 9'h000;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(sel)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [22:0] scpc_start_cycles(input logic [1:0] code);
        logic [22:0] c;
        c = SCPC_BASE_CK;
        case (code)
            2'h1: c = SCPC_BASE_CK + 23'(DLY_SHORT_CYC);
            2'h2: c = SCPC_BASE_CK + 23'(DLY_LONG_CYC);
            default: c = SCPC_BASE_CK;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] trim_reg, trim_next;
    logic [3:0] sel_reg, sel_next;
    logic [3:0] pend_reg, pend_next;
    logic pend_valid_reg, pend_valid_next;
    logic chg_en_reg, chg_en_next;
    logic [2:0] chg_cnt_reg, chg_cnt_next;
    logic timer_ext_reg, timer_ext_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [8:0] div_cnt_reg, div_cnt_next;
    logic clk_en_reg, clk_en_next;
    logic clk_out_reg, clk_out_next;
    logic src_clk_reg, src_clk_next;
    logic timer_clk_reg, timer_clk_next;
    logic ready_reg, ready_next;
    logic [22:0] st_cnt_reg, st_cnt_next;
    scpc_state_type state_reg, state_next;
    logic [3:0] div_sel;
    logic period_end;
    logic wr_div;

    // Active division code; a pending change applies only at a period end
    assign div_sel = sel_reg;
    assign period_end = (div_cnt_reg & scpc_div_mask(div_sel)) == scpc_div_mask(div_sel);
    assign wr_div = WR && (ADDR == SCPC_ADDR_DIV);

    // ------------------------------------------------------------------
    // Register file and unlock sequence
    // ------------------------------------------------------------------
    always_comb begin
        trim_next = trim_reg;
        pend_next = pend_reg;
        pend_valid_next = pend_valid_reg;
        chg_en_next = chg_en_reg;
        chg_cnt_next = chg_cnt_reg;
        timer_ext_next = timer_ext_reg;
        rdata_next = 8'h00;
        if (chg_en_reg) begin
            if (chg_cnt_reg == 3'h1) begin
                chg_en_next = 1'b0;
            end
            chg_cnt_next = chg_cnt_reg - 3'h1;
        end
        if (WR) begin
            case (ADDR)
                SCPC_ADDR_TRIM: trim_next = WDATA;
                SCPC_ADDR_TIMER: timer_ext_next = WDATA[SCPC_TIMER_EXT_BIT];
                SCPC_ADDR_DIV: begin
                    if (WDATA == 8'h80) begin
                        if (!chg_en_reg) begin
                            chg_en_next = 1'b1;
                            chg_cnt_next = SCPC_CHG_WINDOW;
                        end
                    end else if (!WDATA[SCPC_CHG_EN_BIT] && chg_en_reg) begin
                        chg_en_next = 1'b0;
                        chg_cnt_next = 3'h0;
                        if (WDATA[3:0] <= SCPC_SEL_MAX) begin
                            pend_next = WDATA[3:0];
                            pend_valid_next = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (pend_valid_reg && period_end && !wr_div) begin
            pend_valid_next = 1'b0;
        end
        if (RD) begin
            case (ADDR)
                SCPC_ADDR_TRIM: rdata_next = trim_reg;
                // Select field shows the last accepted code, pending or active
                SCPC_ADDR_DIV: rdata_next = {chg_en_reg, 3'h0, pend_valid_reg ? pend_reg : sel_reg};
                SCPC_ADDR_TIMER: rdata_next = {7'h00, timer_ext_reg};
                SCPC_ADDR_STATUS: rdata_next = {6'h00, pend_valid_reg, ready_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            trim_reg <= SCPC_TRIM_FACTORY;
            pend_reg <= SCPC_SEL_DIV1;
            pend_valid_reg <= 1'b0;
            chg_en_reg <= 1'b0;
            chg_cnt_reg <= 3'h0;
            timer_ext_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            trim_reg <= trim_next;
            pend_reg <= pend_next;
            pend_valid_reg <= pend_valid_next;
            chg_en_reg <= chg_en_next;
            chg_cnt_reg <= chg_cnt_next;
            timer_ext_reg <= timer_ext_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Source select and ripple prescaler
    // ------------------------------------------------------------------
    always_comb begin
        case (FUSES.clock_source_select_fuses)
            SCPC_SRC_EXT: src_clk_next = EXT_CLK_IN;
            SCPC_SRC_LP128: src_clk_next = LP_OSC_IN;
            default: src_clk_next = RC_OSC_IN;
        endcase
        timer_clk_next = timer_ext_reg ? TIMER_PIN_IN : TIMER_XTAL_IN;
        div_cnt_next = div_cnt_reg + 9'h001;
        sel_next = sel_reg;
        clk_en_next = period_end;
        // Switch only at the end of a whole old period, then restart the count
        if (pend_valid_reg && period_end) begin
            sel_next = pend_reg;
            div_cnt_next = 9'h000;
        end
        clk_out_next = ~clk_out_reg;
        if (div_sel != SCPC_SEL_DIV1) begin
            clk_out_next = ~period_end ? clk_out_reg : ~clk_out_reg;
        end
        if (!RST_N) begin
            // Settles from the unknown power-up level, then keeps toggling
            if (clk_out_reg) begin
                clk_out_next = 1'b0;
            end else begin
                clk_out_next = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        src_clk_reg <= src_clk_next;
        timer_clk_reg <= timer_clk_next;
        clk_out_reg <= clk_out_next;
        if (!RST_N) begin
            sel_reg <= FUSES.divide_by_eight_fuse ? SCPC_SEL_DIV8 : SCPC_SEL_DIV1;
            div_cnt_reg <= 9'h000;
            clk_en_reg <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            div_cnt_reg <= div_cnt_next;
            clk_en_reg <= clk_en_next;
        end
    end

    // ------------------------------------------------------------------
    // Start-up delay
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        st_cnt_next = st_cnt_reg;
        ready_next = ready_reg;
        case (state_reg)
            SCPC_ST_START, SCPC_ST_WAKE: begin
                if (st_cnt_reg <= 23'h000001) begin
                    state_next = SCPC_ST_RUN;
                    ready_next = 1'b1;
                end else begin
                    st_cnt_next = st_cnt_reg - 23'h000001;
                end
            end
            SCPC_ST_RUN: begin
                if (WAKE_REQ) begin
                    state_next = SCPC_ST_WAKE;
                    st_cnt_next = SCPC_SLEEP_CK;
                    ready_next = 1'b0;
                end
            end
            default: state_next = SCPC_ST_START;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_reg <= SCPC_ST_START;
            st_cnt_reg <= scpc_start_cycles(FUSES.startup_delay_field);
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            st_cnt_reg <= st_cnt_next;
            ready_reg <= ready_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic oe_n_reg;
    logic clk_pin_reg;
    always_ff @(posedge MCLK) begin
        oe_n_reg <= ~FUSES.clock_output_fuse;
        clk_pin_reg <= FUSES.clock_output_fuse ? clk_out_next : 1'b0;
    end

    assign RDATA = rdata_reg;
    assign SRC_CLK = src_clk_reg;
    assign TIMER_CLK = timer_clk_reg;
    assign CLK_EN = clk_en_reg;
    assign CLK_OUT_PIN = clk_pin_reg;
    assign CLK_OUT_OE_N = oe_n_reg;
    assign CORE_READY = ready_reg;
    assign TRIM_FINE = trim_reg[6:0];
    assign TRIM_RANGE = trim_reg[SCPC_TRIM_RANGE_BIT];

endmodule // scpc_top

`default_nettype wire

// file: testbench/scpc_checker_asserts.sv
// Assertion checker for the clock prescaler control block
`timescale 1ns/1ps
`default_nettype none
module scpc_checker
    import scpc_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire scpc_fuse_type FUSES,
    input wire logic EXT_CLK_IN,
    input wire logic LP_OSC_IN,
    input wire logic RC_OSC_IN,
    input wire logic TIMER_PIN_IN,
    input wire logic TIMER_XTAL_IN,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SRC_CLK,
    input wire logic TIMER_CLK,
    input wire logic CLK_EN,
    input wire logic CLK_OUT_PIN,
    input wire logic CLK_OUT_OE_N,
    input wire logic CORE_READY,
    input wire logic [6:0] TRIM_FINE,
    input wire logic TRIM_RANGE
);
    logic ext_reg, ext_next, src_pick;
    logic [7:0] up_reg, up_next;
    logic [8:0] gap_reg, gap_next;
    // Mirror of the timer pin select, cycles since release, cycles since enable
    always_comb begin
        ext_next = (WR && ADDR == SCPC_ADDR_TIMER) ? WDATA[SCPC_TIMER_EXT_BIT] : ext_reg;
        up_next = (up_reg == 8'hFF) ? up_reg : up_reg + 8'h01;
        gap_next = CLK_EN ? 9'h000 : gap_reg + 9'h001;
        src_pick = RC_OSC_IN;
        if (FUSES.clock_source_select_fuses == SCPC_SRC_EXT) begin
            src_pick = EXT_CLK_IN;
        end else if (FUSES.clock_source_select_fuses == SCPC_SRC_LP128) begin
            src_pick = LP_OSC_IN;
        end
    end
    always_ff @(posedge MCLK) begin
        ext_reg <= RST_N ? ext_next : 1'h0;
        up_reg <= RST_N ? up_next : 8'h00;
        gap_reg <= RST_N ? gap_next : 9'h000;
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    oe_level_a: assert property (CLK_OUT_OE_N == !FUSES.clock_output_fuse)
        else $error("Clock pin enable wrong");
    pin_reset_a: assert property (disable iff (1'h0)
        !RST_N && FUSES.clock_output_fuse |-> ##[1:8] $changed(CLK_OUT_PIN))
        else $error("Clock pin idle in reset");
    enable_gap_a: assert property (gap_reg < 9'h100)
        else $error("Divided clock enable missing");
    trim_write_a: assert property (WR && ADDR == SCPC_ADDR_TRIM |=>
        {TRIM_RANGE, TRIM_FINE} == $past(WDATA)) else $error("Trim outputs wrong");
    timer_pick_a: assert property (1'h1 |=>
        TIMER_CLK == $past(ext_reg ? TIMER_PIN_IN : TIMER_XTAL_IN))
        else $error("Timer clock source wrong");
    source_pick_a: assert property (1'h1 |=> SRC_CLK == $past(src_pick))
        else $error("System clock source wrong");
    startup_wait_a: assert property (up_reg < 8'h0D |-> !CORE_READY)
        else $error("Core ready too early");
    unmapped_read_a: assert property (RD && ADDR > SCPC_ADDR_STATUS |=> RDATA == 8'h00)
        else $error("Unmapped read not zero");
endmodule // scpc_checker
bind scpc_top scpc_checker scpc_checker_i (.MCLK, .RST_N, .FUSES, .EXT_CLK_IN, .LP_OSC_IN,
    .RC_OSC_IN, .TIMER_PIN_IN, .TIMER_XTAL_IN, .ADDR, .WDATA, .WR, .RD, .RDATA, .SRC_CLK,
    .TIMER_CLK, .CLK_EN, .CLK_OUT_PIN, .CLK_OUT_OE_N, .CORE_READY, .TRIM_FINE, .TRIM_RANGE);
`default_nettype wire

// file: testbench/scpc_src_model.sv
// Free-running clock source model for the prescaler control bench
`timescale 1ns/1ps
`default_nettype none
module scpc_src_model (
    input wire logic mclk,
    output logic [4:0] src
);
    // Fixed ratios to the master clock keep every source's frequency steady
    initial src = 5'h00;
    always @(posedge mclk) begin
        src <= src + 5'h01;
    end
endmodule // scpc_src_model
`default_nettype wire

// file: testbench/scpc_top_tb.sv
// Self-checking bench for the clock prescaler control block
`timescale 1ns/1ps
`default_nettype none
module scpc_top_tb
    import scpc_pkg::*;
;
    logic mclk = 1'h0;
    logic rst_n = 1'h0;
    logic wr_stb = 1'h0;
    logic rd_stb = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    scpc_fuse_type fuses;
    logic [4:0] src;
    logic [7:0] rdata;
    logic [6:0] trim_fine;
    logic clk_en, clk_out_pin, clk_out_oe_n, core_ready, trim_range, pin_q;
    logic [3:0] sel;
    int errors = 0;
    int compares = 0;
    int n, m;
    always #12.5 mclk = ~mclk;
    scpc_src_model scpc_src_model_i (.mclk(mclk), .src(src));
    scpc_top #(.DLY_SHORT_CYC(10), .DLY_LONG_CYC(20)) scpc_top_i (.MCLK(mclk), .RST_N(rst_n),
        .FUSES(fuses), .EXT_CLK_IN(src[0]), .LP_OSC_IN(src[4]), .RC_OSC_IN(src[1]),
        .TIMER_PIN_IN(src[2]), .TIMER_XTAL_IN(src[3]), .WAKE_REQ(1'h0), .ADDR(addr),
        .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .SRC_CLK(), .TIMER_CLK(),
        .CLK_EN(clk_en), .CLK_OUT_PIN(clk_out_pin), .CLK_OUT_OE_N(clk_out_oe_n),
        .CORE_READY(core_ready), .TRIM_FINE(trim_fine), .TRIM_RANGE(trim_range));
    // ------------------------------------------------------------------
    // Access and measurement tasks
    // ------------------------------------------------------------------
    task check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task conclude();
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task do_reset(input scpc_fuse_type f);
        rst_n <= 1'h0;
        fuses <= f;
        repeat (10) @(posedge mclk);
        rst_n <= 1'h1;
        repeat (30) @(posedge mclk);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'h1;
        @(posedge mclk);
        wr_stb <= 1'h0;
    endtask
    task reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'h1;
        @(posedge mclk);
        rd_stb <= 1'h0;
        #1 check({1'h0, rdata}, {1'h0, exp});
    endtask
    // Cycles up to and including the next divided clock enable
    task gap(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (clk_en !== 1'h1 && k < 600);
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        conclude();
    end
    initial begin
        do_reset('{SCPC_SRC_EXT, 2'h0, 1'h1, 1'h1});
        #1 check(9'(core_ready), 9'h001);
        check(9'(clk_out_oe_n), 9'h000);
        reg_rd(SCPC_ADDR_TRIM, SCPC_TRIM_FACTORY);
        reg_rd(SCPC_ADDR_DIV, {4'h0, SCPC_SEL_DIV8});
        reg_rd(4'hF, 8'h00);
        m = 0;
        pin_q = clk_out_pin;
        repeat (64) begin
            @(posedge mclk);
            #1 m = m + ((clk_out_pin !== pin_q) ? 1 : 0);
            pin_q = clk_out_pin;
        end
        check(9'(m), 9'h008);
        wr(SCPC_ADDR_DIV, 8'h02);
        reg_rd(SCPC_ADDR_DIV, 8'h03);
        wr(SCPC_ADDR_DIV, 8'h81);
        reg_rd(SCPC_ADDR_DIV, 8'h03);
        wr(SCPC_ADDR_DIV, 8'h80);
        reg_rd(SCPC_ADDR_DIV, 8'h83);
        reg_rd(SCPC_ADDR_DIV, 8'h83);
        reg_rd(SCPC_ADDR_DIV, 8'h03);
        wr(SCPC_ADDR_DIV, 8'h80);
        wr(SCPC_ADDR_DIV, 8'h80);
        reg_rd(SCPC_ADDR_DIV, 8'h83);
        wr(SCPC_ADDR_DIV, 8'h01);
        reg_rd(SCPC_ADDR_DIV, 8'h03);
        wr(SCPC_ADDR_DIV, 8'h80);
        wr(SCPC_ADDR_DIV, 8'h09);
        reg_rd(SCPC_ADDR_DIV, 8'h03);
        wr(SCPC_ADDR_TRIM, 8'h7F);
        #1 check(9'({trim_range, trim_fine}), 9'h07F);
        wr(SCPC_ADDR_TRIM, 8'h80);
        #1 check(9'({trim_range, trim_fine}), 9'h080);
        wr(SCPC_ADDR_TIMER, 8'h01);
        reg_rd(SCPC_ADDR_TIMER, 8'h01);
        repeat (8) @(posedge mclk);
        wr(SCPC_ADDR_TIMER, 8'h00);
        sel = SCPC_SEL_DIV8;
        for (int c = 0; c <= 8; c++) begin
            wr(SCPC_ADDR_DIV, 8'h80);
            reg_rd(SCPC_ADDR_DIV, {4'h8, sel});
            wr(SCPC_ADDR_DIV, 8'(c));
            reg_rd(SCPC_ADDR_DIV, 8'(c));
            gap(n);
            gap(n);
            check(9'(n >= (1 << ((c < sel) ? c : sel))), 9'h001);
            gap(n);
            check(9'(n), 9'(1 << c));
            sel = 4'(c);
        end
        do_reset('{SCPC_SRC_LP128, 2'h0, 1'h0, 1'h0});
        reg_rd(SCPC_ADDR_DIV, {4'h0, SCPC_SEL_DIV1});
        check({7'h00, clk_out_oe_n, clk_out_pin}, 9'h002);
        conclude();
    end
endmodule // scpc_top_tb
`default_nettype wire
